/* rtl/acmp_top.sv */
// comparator input selection, sync, events, irq and apb registers
`timescale 1ns/1ps
`include "acmp_consts.svh"
module acmp_top import acmp_pkg::*; #(
   parameter int AW = 10,
   parameter int NCH = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`ACMP_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [AW-1:0] i_positive_pin,
   input wire logic [AW-1:0] i_negative_pin,
   input wire logic [AW-1:0] i_bandgap_level,
   input wire logic [NCH-1:0][AW-1:0] i_converter_inputs,
   input wire logic i_converter_enable,
   input wire logic [2:0] i_channel_select,
   input wire logic i_global_irq_enable,
   input wire logic i_irq_vector_ack,
   output logic o_cmp_irq_req,
   output logic o_capture_input,
   output logic o_cmp_power_on,
   output logic o_pos_source,
   output logic [3:0] o_neg_source,
   output logic o_irq
);
   acmp_byte_t sfio_ff;
   logic disable_ff;
   logic bgsel_ff;
   logic flag_ff;
   logic irqen_ff;
   logic capen_ff;
   acmp_mode_t mode_ff;
   logic [`ACMP_IRQ_W-1:0] irq_stat_ff;
   logic [`ACMP_IRQ_W-1:0] irq_mask_ff;
   logic prev_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic cmp_irq_req_ff;
   logic capture_ff;
   logic pos_src_ff;
   acmp_src_t neg_src_ff;
   logic irq_ff;

   logic setup;
   logic wr_fire;
   logic lane0;
   logic hit_sfio;
   logic hit_csr;
   logic hit_stat;
   logic hit_mask;
   logic mapped;
   logic mux_active;
   logic [AW-1:0] pos_val;
   logic [AW-1:0] neg_val;
   logic raw_result;
   logic cmp_sync;
   logic rise;
   logic fall;
   logic event_hit;
   logic flag_clr;
   acmp_byte_t csr_view;
   logic [31:0] nxt_prdata;
   logic [`ACMP_IRQ_W-1:0] irq_set;

   // ---------------- apb decode ----------------
   assign setup = i_psel & ~i_penable;
   assign wr_fire = i_psel & i_penable & pready_ff & i_pwrite;
   assign lane0 = i_pstrb[0];
   assign hit_sfio = (i_paddr == `ACMP_OFS_SFIO);
   assign hit_csr = (i_paddr == `ACMP_OFS_CSR);
   assign hit_stat = (i_paddr == `ACMP_OFS_IRQ_STAT);
   assign hit_mask = (i_paddr == `ACMP_OFS_IRQ_MASK);
   assign mapped = hit_sfio | hit_csr | hit_stat | hit_mask;

   // ---------------- analog front end model ----------------
   assign mux_active = sfio_ff[`ACMP_SFIO_MUXEN_BIT] &
      ~i_converter_enable;
   assign neg_val = mux_active ? i_converter_inputs[i_channel_select] :
      i_negative_pin;
   assign pos_val = bgsel_ff ? i_bandgap_level : i_positive_pin;
   // powered-off comparator rests low
   assign raw_result = ~disable_ff & (pos_val > neg_val);

   acmp_sync #(
      .STAGES(`ACMP_SYNC_STAGES)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_d(raw_result),
      .o_q(cmp_sync)
   );

   // ---------------- event detection ----------------
   assign rise = cmp_sync & ~prev_ff;
   assign fall = ~cmp_sync & prev_ff;

   always_comb begin
      unique case (mode_ff)
         `ACMP_MODE_TOGGLE: event_hit = rise | fall;
         `ACMP_MODE_RESERVED: event_hit = 1'b0;
         `ACMP_MODE_FALL: event_hit = fall;
         `ACMP_MODE_RISE: event_hit = rise;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= cmp_sync;
      end
   end

   // ---------------- special function register ----------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         sfio_ff <= `ACMP_SFIO_RESET;
      end else if (wr_fire & hit_sfio & lane0) begin
         sfio_ff <= i_pwdata[7:0] & `ACMP_SFIO_WMASK;
      end
   end

   // ---------------- control and status register ----------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         disable_ff <= 1'b0;
         bgsel_ff <= 1'b0;
         irqen_ff <= 1'b0;
         capen_ff <= 1'b0;
         mode_ff <= `ACMP_MODE_TOGGLE;
      end else if (wr_fire & hit_csr & lane0) begin
         disable_ff <= i_pwdata[`ACMP_CSR_DISABLE_BIT];
         bgsel_ff <= i_pwdata[`ACMP_CSR_BGSEL_BIT];
         irqen_ff <= i_pwdata[`ACMP_CSR_IRQEN_BIT];
         capen_ff <= i_pwdata[`ACMP_CSR_CAPEN_BIT];
         mode_ff <= {i_pwdata[`ACMP_CSR_MODE_HI_BIT],
            i_pwdata[`ACMP_CSR_MODE_LO_BIT]};
      end
   end

   // an event in the clearing cycle wins over the clear
   assign flag_clr = (wr_fire & hit_csr & lane0 &
      i_pwdata[`ACMP_CSR_FLAG_BIT]) | i_irq_vector_ack;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_ff <= 1'b0;
      end else if (event_hit) begin
         flag_ff <= 1'b1;
      end else if (flag_clr) begin
         flag_ff <= 1'b0;
      end
   end

   always_comb begin
      csr_view = '0;
      csr_view[`ACMP_CSR_DISABLE_BIT] = disable_ff;
      csr_view[`ACMP_CSR_BGSEL_BIT] = bgsel_ff;
      csr_view[`ACMP_CSR_OUT_BIT] = cmp_sync;
      csr_view[`ACMP_CSR_FLAG_BIT] = flag_ff;
      csr_view[`ACMP_CSR_IRQEN_BIT] = irqen_ff;
      csr_view[`ACMP_CSR_CAPEN_BIT] = capen_ff;
      csr_view[`ACMP_CSR_MODE_HI_BIT] = mode_ff[1];
      csr_view[`ACMP_CSR_MODE_LO_BIT] = mode_ff[0];
   end

   // ---------------- system interrupt status and mask ----------------
   always_comb begin
      irq_set = '0;
      irq_set[`ACMP_IRQ_FLAG_BIT] = event_hit;
      irq_set[`ACMP_IRQ_TOGGLE_BIT] = rise | fall;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat_ff <= '0;
      end else if (wr_fire & hit_stat & lane0) begin
         irq_stat_ff <= (irq_stat_ff & ~i_pwdata[`ACMP_IRQ_W-1:0]) |
            irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_ff <= '0;
      end else if (wr_fire & hit_mask & lane0) begin
         irq_mask_ff <= i_pwdata[`ACMP_IRQ_W-1:0];
      end
   end

   // ---------------- apb read path ----------------
   always_comb begin
      nxt_prdata = '0;
      if (hit_sfio) begin
         nxt_prdata[7:0] = sfio_ff;
      end else if (hit_csr) begin
         nxt_prdata[7:0] = csr_view;
      end else if (hit_stat) begin
         nxt_prdata[`ACMP_IRQ_W-1:0] = irq_stat_ff;
      end else if (hit_mask) begin
         nxt_prdata[`ACMP_IRQ_W-1:0] = irq_mask_ff;
      end
   end

   // zero wait: data captured at setup, ready in the first access cycle
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & ~mapped;
         if (setup & ~i_pwrite) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   // ---------------- registered block outputs ----------------
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cmp_irq_req_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         cmp_irq_req_ff <= flag_ff & irqen_ff & i_global_irq_enable;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // gated to zero so the timer sees no stale level when disconnected
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         capture_ff <= 1'b0;
      end else begin
         capture_ff <= capen_ff & cmp_sync;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         pos_src_ff <= `ACMP_SRC_POS_PIN;
         neg_src_ff <= `ACMP_SRC_NEG_PIN;
      end else begin
         pos_src_ff <= bgsel_ff ? `ACMP_SRC_BANDGAP : `ACMP_SRC_POS_PIN;
         neg_src_ff <= mux_active ? acmp_src_t'({1'b0, i_channel_select} +
            4'h1) : `ACMP_SRC_NEG_PIN;
      end
   end

   assign o_prdata = prdata_ff;
   assign o_pready = pready_ff;
   assign o_pslverr = pslverr_ff;
   assign o_cmp_irq_req = cmp_irq_req_ff;
   assign o_capture_input = capture_ff;
   assign o_cmp_power_on = ~disable_ff;
   assign o_pos_source = pos_src_ff;
   assign o_neg_source = neg_src_ff;
   assign o_irq = irq_ff;

   // ---------------- assertions ----------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   sequence s_csr_write;
      wr_fire & hit_csr & lane0;
   endsequence

   sequence s_flag_clear_write;
      s_csr_write ##0 i_pwdata[`ACMP_CSR_FLAG_BIT] & ~event_hit;
   endsequence

   sequence s_sfio_read;
      setup & ~i_pwrite & hit_sfio ##1 pready_ff;
   endsequence

   property p_sync_delay;
      ##2 cmp_sync == $past(raw_result, 2);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("synchronised output is not raw result two cycles late");

   property p_rise_sets_flag;
      (mode_ff == `ACMP_MODE_RISE) & ~prev_ff & cmp_sync |=> flag_ff;
   endproperty
   a_rise_sets_flag: assert property (p_rise_sets_flag)
      else $error("rising edge in rising mode did not set flag");

   property p_fall_mode_ignores_rise;
      (mode_ff == `ACMP_MODE_FALL) & ~flag_ff & cmp_sync & ~prev_ff
         |=> ~flag_ff;
   endproperty
   a_fall_mode_ignores_rise: assert property (p_fall_mode_ignores_rise)
      else $error("rising edge set flag in falling mode");

   property p_reserved_silent;
      (mode_ff == `ACMP_MODE_RESERVED) & ~flag_ff |=> ~flag_ff;
   endproperty
   a_reserved_silent: assert property (p_reserved_silent)
      else $error("reserved mode produced a flag event");

   property p_irq_request;
      ##1 o_cmp_irq_req ==
         $past(flag_ff & irqen_ff & i_global_irq_enable);
   endproperty
   a_irq_request: assert property (p_irq_request)
      else $error("irq request disagrees with flag and enables");

   property p_vector_clears;
      i_irq_vector_ack & ~event_hit |=> ~flag_ff;
   endproperty
   a_vector_clears: assert property (p_vector_clears)
      else $error("vector acknowledge did not clear flag");

   property p_write_one_clears;
      s_flag_clear_write |=> ~flag_ff;
   endproperty
   a_write_one_clears: assert property (p_write_one_clears)
      else $error("writing one did not clear flag");

   property p_write_zero_keeps;
      s_csr_write ##0 ~i_pwdata[`ACMP_CSR_FLAG_BIT] & flag_ff
         & ~i_irq_vector_ack |=> flag_ff;
   endproperty
   a_write_zero_keeps: assert property (p_write_zero_keeps)
      else $error("writing zero changed flag");

   property p_capture_follows;
      capen_ff |=> o_capture_input == $past(cmp_sync);
   endproperty
   a_capture_follows: assert property (p_capture_follows)
      else $error("capture input does not follow comparator");

   property p_capture_cut;
      ~capen_ff |=> ~o_capture_input;
   endproperty
   a_capture_cut: assert property (p_capture_cut)
      else $error("capture input driven while disconnected");

   property p_disable_write;
      s_csr_write ##0 i_pwdata[`ACMP_CSR_DISABLE_BIT]
         |=> ~o_cmp_power_on ##2 ~cmp_sync;
   endproperty
   a_disable_write: assert property (p_disable_write)
      else $error("disable write did not power comparator down");

   property p_neg_mux;
      mux_active |=> o_neg_source == 4'($past(i_channel_select)) + 4'h1;
   endproperty
   a_neg_mux: assert property (p_neg_mux)
      else $error("negative source not the selected converter input");

   property p_neg_pin;
      ~mux_active |=> o_neg_source == `ACMP_SRC_NEG_PIN;
   endproperty
   a_neg_pin: assert property (p_neg_pin)
      else $error("negative source not the dedicated pin");

   property p_bandgap;
      bgsel_ff |=> o_pos_source == `ACMP_SRC_BANDGAP;
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap select ignored");

   property p_raw_compare;
      raw_result |-> ~disable_ff & (pos_val > neg_val);
   endproperty
   a_raw_compare: assert property (p_raw_compare)
      else $error("raw result high without positive above negative");

   property p_sfio_bit4;
      s_sfio_read |-> o_prdata[4] == 1'b0;
   endproperty
   a_sfio_bit4: assert property (p_sfio_bit4)
      else $error("special function bit 4 read as one");
endmodule // acmp_top

/* rtl/acmp_consts.svh */
// constants and register layout of the analog comparator control block
`ifndef ACMP_CONSTS_SVH
`define ACMP_CONSTS_SVH

`define ACMP_ADDR_W 12
`define ACMP_OFS_SFIO 12'h000
`define ACMP_OFS_CSR 12'h004
`define ACMP_OFS_IRQ_STAT 12'h008
`define ACMP_OFS_IRQ_MASK 12'h00C

`define ACMP_SFIO_RESET 8'h00
`define ACMP_SFIO_WMASK 8'hEF
`define ACMP_SFIO_MUXEN_BIT 3

`define ACMP_CSR_DISABLE_BIT 7
`define ACMP_CSR_BGSEL_BIT 6
`define ACMP_CSR_OUT_BIT 5
`define ACMP_CSR_FLAG_BIT 4
`define ACMP_CSR_IRQEN_BIT 3
`define ACMP_CSR_CAPEN_BIT 2
`define ACMP_CSR_MODE_HI_BIT 1
`define ACMP_CSR_MODE_LO_BIT 0

`define ACMP_MODE_TOGGLE 2'h0
`define ACMP_MODE_RESERVED 2'h1
`define ACMP_MODE_FALL 2'h2
`define ACMP_MODE_RISE 2'h3

`define ACMP_IRQ_W 2
`define ACMP_IRQ_FLAG_BIT 0
`define ACMP_IRQ_TOGGLE_BIT 1

`define ACMP_SYNC_STAGES 2
`define ACMP_SRC_NEG_PIN 4'h0
`define ACMP_SRC_POS_PIN 1'h0
`define ACMP_SRC_BANDGAP 1'h1

`endif

/* rtl/acmp_pkg.sv */
// shared types of the analog comparator control block
package acmp_pkg;
   typedef logic [7:0] acmp_byte_t;
   typedef logic [1:0] acmp_mode_t;
   typedef logic [3:0] acmp_src_t;
endpackage

/* rtl/acmp_sync.sv */
// multi-stage level synchroniser
`timescale 1ns/1ps
module acmp_sync #(
   parameter int STAGES = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_d,
   output logic o_q
);
   logic [STAGES-1:0] chain_ff;

   // only the last stage is read outside
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         chain_ff <= '0;
      end else begin
         chain_ff <= {chain_ff[STAGES-2:0], i_d};
      end
   end

   assign o_q = chain_ff[STAGES-1];
endmodule // acmp_sync

/* test/acmp_far_model.sv */
// timer capture front end as seen from the far side of the comparator
`timescale 1ns/1ps
module acmp_far_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_capture_input,
   input wire logic i_timer_capture_irq_mask,
   output logic o_capture_irq,
   output logic [7:0] o_capture_count
);
   logic prev_ff;
   // rising edges counted; the interrupt needs the mask bit as well
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_ff <= 1'b0;
         o_capture_count <= 8'h00;
         o_capture_irq <= 1'b0;
      end else begin
         prev_ff <= i_capture_input;
         if (i_capture_input && !prev_ff) begin
            o_capture_count <= o_capture_count + 8'h01;
         end
         o_capture_irq <= i_capture_input && !prev_ff &&
            i_timer_capture_irq_mask;
      end
   end
endmodule // acmp_far_model

/* test/analog_comparator_control_bench.sv */
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`include "acmp_consts.svh"
module analog_comparator_control_bench import acmp_pkg::*;;
   localparam logic [11:0] a_sf = `ACMP_OFS_SFIO;
   localparam logic [11:0] a_cs = `ACMP_OFS_CSR;
   localparam logic [11:0] a_st = `ACMP_OFS_IRQ_STAT;
   localparam logic [11:0] a_mk = `ACMP_OFS_IRQ_MASK;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, r;
   logic [3:0] strb, neg_src;
   logic [9:0] pos, neg, bg;
   logic [7:0][9:0] conv;
   logic conv_en, gie, ack, irq_req, cap_in, pwr_on, pos_src, irq;
   logic [2:0] ch;
   logic cap_mask;
   logic [7:0] cap_cnt, cnt0;
   int n_mismatch, checks;

   acmp_top #(.AW(10), .NCH(8)) acmp_top_i (
      .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_positive_pin(pos), .i_negative_pin(neg),
      .i_bandgap_level(bg), .i_converter_inputs(conv),
      .i_converter_enable(conv_en), .i_channel_select(ch),
      .i_global_irq_enable(gie), .i_irq_vector_ack(ack),
      .o_cmp_irq_req(irq_req), .o_capture_input(cap_in),
      .o_cmp_power_on(pwr_on), .o_pos_source(pos_src),
      .o_neg_source(neg_src), .o_irq(irq));

   acmp_far_model acmp_far_model_i (
      .i_ref_clk(clk), .i_rst(rst), .i_capture_input(cap_in),
      .i_timer_capture_irq_mask(cap_mask), .o_capture_irq(),
      .o_capture_count(cap_cnt));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic exp_out(logic b, logic me, logic ce);
      logic [9:0] p, n;
      p = b ? bg : pos;
      n = (me && !ce) ? conv[ch] : neg;
      return p > n;
   endfunction

   function automatic logic exp_ev(int m, logic rise);
      return m == 0 || (m == 3 && rise) || (m == 2 && !rise);
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one idle cycle after each transfer keeps drivers single per step
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic lvl(input logic v);
      pos <= v ? 10'h3FF : 10'h000;
      neg <= 10'h200;
      cyc(5);
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      cyc(20000);
      n_mismatch++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, conv_en, gie, ack, cap_mask} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      strb = 4'hF;
      {pos, neg, bg, ch} = 33'h0;
      seed = 32'h428F;
      for (int i = 0; i < 8; i++) conv[i] = 10'(xs());
      cyc(2);
      rst <= 1'b0;
      @(posedge clk);
      chk("power_on", pwr_on, 1);
      for (int i = 0; i < 5; i++) begin
         apb(0, 12'(i * 4), 0);
         chk("reset_value", rd, 0);
         chk("slverr", err, i == 4);
      end
      apb(1, a_sf, 32'hFF);
      apb(0, a_sf, 0);
      chk("sfio_ro", rd, 32'hEF);
      for (int i = 0; i < 32; i++) begin
         r = xs();
         apb(1, a_sf, {28'h0, r[0], 3'h0});
         apb(1, a_cs, {25'h0, r[1], 6'h00});
         ch <= i[2:0];
         conv_en <= r[2];
         pos <= r[13:4];
         neg <= r[23:14];
         bg <= r[31:22];
         conv[i[2:0]] <= 10'(xs());
         cyc(4);
         apb(0, a_cs, 0);
         chk("out", rd[5], exp_out(r[1], r[0], r[2]));
         chk("neg_src", neg_src,
            (r[0] && !r[2]) ? 4'(i[2:0]) + 4'h1 : 4'h0);
         chk("pos_src", pos_src, r[1]);
      end
      apb(1, a_sf, 0);
      lvl(0);
      for (int m = 0; m < 4; m++) begin
         apb(1, a_cs, {28'h1, 2'h0, 2'(m)});
         lvl(1);
         apb(0, a_cs, 0);
         chk("rise_flag", rd[4], exp_ev(m, 1));
         apb(1, a_cs, {28'h1, 2'h0, 2'(m)});
         apb(0, a_cs, 0);
         chk("flag_w1c", rd[4], 0);
         lvl(0);
         apb(1, a_cs, {30'h0, 2'(m)});
         apb(0, a_cs, 0);
         chk("fall_flag", rd[4], exp_ev(m, 0));
      end
      apb(1, a_cs, 32'h1B);
      gie <= 1'b1;
      lvl(1);
      chk("irq_req", irq_req, 1);
      gie <= 1'b0;
      cyc(3);
      chk("irq_req_gie", irq_req, 0);
      gie <= 1'b1;
      cyc(3);
      chk("irq_req_back", irq_req, 1);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      cyc(3);
      chk("irq_req_ack", irq_req, 0);
      apb(0, a_cs, 0);
      chk("flag_ack", rd[4], 0);
      apb(1, a_cs, 32'h14);
      cap_mask <= 1'b1;
      // enabling capture while high gives an edge of its own
      lvl(0);
      cnt0 = cap_cnt;
      lvl(1);
      chk("capture", cap_in, 1);
      chk("capture_cnt", cap_cnt, cnt0 + 8'h01);
      apb(1, a_cs, 32'h10);
      lvl(0);
      lvl(1);
      chk("no_capture", cap_in, 0);
      chk("no_capture_cnt", cap_cnt, cnt0 + 8'h01);
      apb(1, a_st, 32'h3);
      apb(1, a_mk, 32'h1);
      lvl(0);
      chk("irq_on", irq, 1);
      apb(1, a_mk, 0);
      cyc(2);
      chk("irq_masked", irq, 0);
      apb(1, a_mk, 32'h1);
      cyc(2);
      chk("irq_unmasked", irq, 1);
      apb(1, a_st, 32'h3);
      cyc(2);
      chk("irq_cleared", irq, 0);
      apb(0, a_st, 0);
      chk("status", rd, 0);
      lvl(1);
      apb(1, a_cs, 32'h80);
      cyc(4);
      chk("power_off", pwr_on, 0);
      apb(0, a_cs, 0);
      chk("out_off", rd[7:5], 3'h4);
      apb(1, a_cs, 0);
      chk("power_back", pwr_on, 1);
      complete_run();
   end
endmodule // analog_comparator_control_bench
